// File: logic/por_defs.svh
`ifndef POR_DEFS_SVH
`define POR_DEFS_SVH

// Core clock rate
`define POR_CLK_HZ          50000000
// Delay from chip-enable rise to threshold restore, in ms
`define POR_CE_THR_DELAY_MS 50
`define POR_CE_THR_DELAY_CYC (`POR_CE_THR_DELAY_MS * (`POR_CLK_HZ / 1000))
// Carry setting period loaded by system init, in ms
`define POR_CARRY_INIT_MS   100
// Width of the threshold restore counter
`define POR_CNT_W           22
// Reset values
`define POR_RST_SUPPLY_LOW  1'h1
`define POR_RST_DISABLE     1'h1
`define POR_RST_FLAG        1'h0
`define POR_RST_THR_HIGH    1'h1
// Reset values of the sequencer outputs
`define POR_RST_HOLD        1'h1
`define POR_RST_RUN         1'h0

`endif

// File: logic/por_pkg.sv
package por_pkg;

    // Gray codes along clear -> armed -> run -> stop -> chip-enable wait
    typedef enum logic [2:0] {
        st_clear   = 3'h0,
        st_armed   = 3'h1,
        st_run     = 3'h3,
        st_stop    = 3'h2,
        st_ce_wait = 3'h6
    } state_type;

endpackage

// File: logic/level_sync.sv
`timescale 1ns/10ps
module level_sync #(
    parameter int           WIDTH     = 1,
    parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // Levels
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage_one;

    // First stage feeds only the second one
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stage_one <= RST_VALUE;
            level_out <= RST_VALUE;
        end else begin
            stage_one <= level_in;
            level_out <= stage_one;
        end
    end

endmodule // level_sync

// File: logic/power_on_reset_and_fail_detect.sv
// Overview of operation
// - While supply low clear is active, stop the oscillator and all execution.
// - All three internal resets held during clear, released together with oscillator.
// - After clear ends, core stays halted until next carry setting rising edge.
// - System init loads a 100 ms carry period; program starts about 50 ms later.
// - Core registers initialize as soon as supply low clear becomes active.
// - Threshold is 3.5 V in normal operation and halt, 2.2 V in stop.
// - Low supply in normal operation stops device regardless of chip enable.
// - After a low event in stop, restart only when supply exceeds 3.5 V.
// - Chip enable rising with supply or during forced halt gives one start.
// - Chip enable rising after the start restarts at next carry setting edge.
// - Leaving stop via chip enable, threshold returns to 3.5 V after 50 ms.
// - Threshold switches to 2.2 V when the stop instruction enters back-up.
// - Carry disable is set by supply low clear, cleared by a flag read.
// - While carry disable is 1, the carry watch flag cannot be set.
// - After power-on the flag starts clear and stays clear until first read.
// - After the first read, each carry setting rising edge sets the flag.
// - Software reads the flag: 0 means power failure, 1 means chip enable.
// - Reading the carry watch flag clears it to 0, unless a carry edge sets it in the same cycle.
`timescale 1ns/10ps
`include "por_defs.svh"
module power_on_reset_and_fail_detect
    import por_pkg::*;
#(
    parameter int CNT_W            = `POR_CNT_W,
    parameter int CE_THR_CYCLES    = `POR_CE_THR_DELAY_CYC,
    parameter int CARRY_INIT_MS    = `POR_CARRY_INIT_MS
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Analog detector
    input  wire logic supply_low_raw,
    output logic      threshold_high,
    // Pins and core events
    input  wire logic ce_pin,
    input  wire logic carry_set,
    input  wire logic clock_stop_cmd,
    input  wire logic flag_read,
    // Core control
    output logic      supply_low_clear,
    output logic      osc_enable,
    output logic      exec_enable,
    output logic      halt_wake_by_carry,
    output logic      core_init_hold,
    output logic      system_init,
    output logic      restart_at_zero,
    // Failure detection
    output logic      carry_watch_flag,
    output logic      carry_disable
);

    state_type          state;
    state_type          next_state;
    logic               low;
    logic               ce_prev;
    logic               carry_prev;
    logic               ce_rise;
    logic               carry_rise;
    logic [CNT_W-1:0]   thr_count;

    // Comparator output is asynchronous to the core clock
    level_sync #(
        .WIDTH     (1),
        .RST_VALUE (`POR_RST_SUPPLY_LOW)
    ) u_low_sync (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .level_in  (supply_low_raw),
        .level_out (low)
    );

    // Edge detection on pins
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ce_prev    <= 1'h0;
            carry_prev <= 1'h0;
        end else begin
            ce_prev    <= ce_pin;
            carry_prev <= carry_set;
        end
    end

    assign ce_rise    = ce_pin & ~ce_prev;
    assign carry_rise = carry_set & ~carry_prev;

    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            st_clear: begin
                if (!low) begin
                    next_state = st_armed;
                end
            end
            st_armed: begin
                // Chip enable edges here fold into the power-on start
                if (carry_rise) begin
                    next_state = st_run;
                end
            end
            st_run: begin
                if (clock_stop_cmd) begin
                    next_state = st_stop;
                end else if (ce_rise) begin
                    next_state = st_ce_wait;
                end
            end
            st_stop: begin
                if (ce_rise) begin
                    next_state = st_ce_wait;
                end
            end
            st_ce_wait: begin
                if (carry_rise) begin
                    next_state = st_run;
                end
            end
            default: begin
                next_state = st_clear;
            end
        endcase
        // Low supply wins over every mode and over the pin
        if (low) begin
            next_state = st_clear;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= st_clear;
        end else begin
            state <= next_state;
        end
    end

    // Control outputs follow the next state so they change with it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            supply_low_clear   <= `POR_RST_HOLD;
            osc_enable         <= `POR_RST_RUN;
            exec_enable        <= `POR_RST_RUN;
            halt_wake_by_carry <= `POR_RST_HOLD;
            core_init_hold     <= `POR_RST_HOLD;
            system_init        <= `POR_RST_HOLD;
        end else begin
            supply_low_clear   <= (next_state == st_clear);
            osc_enable         <= (next_state != st_clear) && (next_state != st_stop);
            exec_enable        <= (next_state == st_run) || (next_state == st_ce_wait);
            halt_wake_by_carry <= (next_state == st_clear);
            core_init_hold     <= (next_state == st_clear);
            system_init        <= (next_state == st_clear);
        end
    end

    // One-cycle start at address zero
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            restart_at_zero <= `POR_RST_RUN;
        end else begin
            restart_at_zero <= ((state == st_armed) || (state == st_ce_wait))
                               && carry_rise && !low;
        end
    end

    // Threshold restore delay after chip enable leaves stop
    always_ff @(posedge mclk) begin
        if (sys_rst || low) begin
            thr_count <= '0;
        end else if ((state == st_stop) && ce_rise) begin
            thr_count <= CNT_W'(CE_THR_CYCLES);
        end else if ((next_state == st_stop) && (state != st_stop)) begin
            // A pending restore must not lift the threshold in stop
            thr_count <= '0;
        end else if (thr_count != '0) begin
            thr_count <= thr_count - CNT_W'(1);
        end
    end

    // Threshold select
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            threshold_high <= `POR_RST_THR_HIGH;
        end else if (low) begin
            // Recovery from any low event needs the high threshold
            threshold_high <= 1'h1;
        end else if ((next_state == st_stop) && (state != st_stop)) begin
            threshold_high <= 1'h0;
        end else if (thr_count == CNT_W'(1)) begin
            threshold_high <= 1'h1;
        end
    end

    // Carry disable
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            carry_disable <= `POR_RST_DISABLE;
        end else if (low) begin
            carry_disable <= 1'h1;
        end else if (flag_read) begin
            carry_disable <= 1'h0;
        end
    end

    // Carry watch flag; a carry edge wins over a read in the same cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            carry_watch_flag <= `POR_RST_FLAG;
        end else if (low) begin
            carry_watch_flag <= 1'h0;
        end else if (carry_rise && !carry_disable) begin
            carry_watch_flag <= 1'h1;
        end else if (flag_read) begin
            carry_watch_flag <= 1'h0;
        end
    end

    property p_clear_stops_core;
        @(posedge mclk) disable iff (sys_rst)
        low |=> (!osc_enable && !exec_enable);
    endproperty
    a_clear_stops_core: assert property (p_clear_stops_core)
        else $error("oscillator or execution active during supply clear");

    property p_resets_together;
        @(posedge mclk) disable iff (sys_rst)
        (halt_wake_by_carry == core_init_hold) && (core_init_hold == system_init)
        && (core_init_hold == (state == st_clear));
    endproperty
    a_resets_together: assert property (p_resets_together)
        else $error("internal resets out of step");

    property p_armed_waits;
        @(posedge mclk) disable iff (sys_rst)
        (state == st_armed) && !carry_rise && !low |=> (state == st_armed) && !exec_enable;
    endproperty
    a_armed_waits: assert property (p_armed_waits)
        else $error("core left halt without carry edge");

    property p_armed_start;
        @(posedge mclk) disable iff (sys_rst)
        (state == st_armed) && carry_rise && !low |=> restart_at_zero ##1 !restart_at_zero;
    endproperty
    a_armed_start: assert property (p_armed_start)
        else $error("missing single start pulse");

    property p_stop_low_threshold;
        @(posedge mclk) disable iff (sys_rst)
        $rose(state == st_stop) |-> !threshold_high && !osc_enable;
    endproperty
    a_stop_low_threshold: assert property (p_stop_low_threshold)
        else $error("threshold not lowered in stop");

    property p_restore_threshold;
        @(posedge mclk) disable iff (sys_rst)
        (thr_count == CNT_W'(1)) && !low |=> threshold_high;
    endproperty
    a_restore_threshold: assert property (p_restore_threshold)
        else $error("threshold not restored after delay");

    property p_clear_sets_disable;
        @(posedge mclk) disable iff (sys_rst)
        low |=> carry_disable && !carry_watch_flag;
    endproperty
    a_clear_sets_disable: assert property (p_clear_sets_disable)
        else $error("disable not set by supply clear");

    property p_disable_blocks;
        @(posedge mclk) disable iff (sys_rst)
        carry_disable |=> !$rose(carry_watch_flag);
    endproperty
    a_disable_blocks: assert property (p_disable_blocks)
        else $error("flag set while disabled");

    property p_read_clears;
        @(posedge mclk) disable iff (sys_rst)
        flag_read && !carry_rise && !low |=> !carry_watch_flag ##0 !carry_disable;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("flag read did not clear");

    property p_ce_in_forced_halt;
        @(posedge mclk) disable iff (sys_rst)
        (state == st_armed) && ce_rise && !carry_rise && !low |=> (state == st_armed);
    endproperty
    a_ce_in_forced_halt: assert property (p_ce_in_forced_halt)
        else $error("chip enable disturbed forced halt");

    property p_ce_restart;
        @(posedge mclk) disable iff (sys_rst)
        (state == st_run) && ce_rise && !low && !clock_stop_cmd |=> (state == st_ce_wait);
    endproperty
    a_ce_restart: assert property (p_ce_restart)
        else $error("chip enable restart not armed");

    property p_stop_holds_low_threshold;
        @(posedge mclk) disable iff (sys_rst)
        (state == st_stop) |-> !threshold_high;
    endproperty
    a_stop_holds_low_threshold: assert property (p_stop_holds_low_threshold)
        else $error("high threshold selected in stop");

    property p_armed_high_threshold;
        @(posedge mclk) disable iff (sys_rst)
        (state == st_armed) |-> threshold_high;
    endproperty
    a_armed_high_threshold: assert property (p_armed_high_threshold)
        else $error("low threshold selected after clear");

    property p_clear_ignores_pin;
        @(posedge mclk) disable iff (sys_rst)
        (state == st_clear) && low |=> (state == st_clear) && supply_low_clear;
    endproperty
    a_clear_ignores_pin: assert property (p_clear_ignores_pin)
        else $error("left clear while supply low");

    property p_release_together;
        @(posedge mclk) disable iff (sys_rst)
        $fell(supply_low_clear) |-> osc_enable && !halt_wake_by_carry && !core_init_hold
        && !system_init;
    endproperty
    a_release_together: assert property (p_release_together)
        else $error("resets or oscillator not released with clear");

    property p_clear_inits_core;
        @(posedge mclk) disable iff (sys_rst)
        low |=> core_init_hold && halt_wake_by_carry;
    endproperty
    a_clear_inits_core: assert property (p_clear_inits_core)
        else $error("core not held at supply clear");

    property p_stop_entry;
        @(posedge mclk) disable iff (sys_rst)
        (state == st_run) && clock_stop_cmd && !low |=> (state == st_stop) && !threshold_high
        && !exec_enable;
    endproperty
    a_stop_entry: assert property (p_stop_entry)
        else $error("stop command not taken");

    property p_stop_ce_loads;
        @(posedge mclk) disable iff (sys_rst)
        (state == st_stop) && ce_rise && !low |=> (state == st_ce_wait)
        && (thr_count == CNT_W'(CE_THR_CYCLES));
    endproperty
    a_stop_ce_loads: assert property (p_stop_ce_loads)
        else $error("restore delay not started from stop");

    property p_carry_sets_flag;
        @(posedge mclk) disable iff (sys_rst)
        carry_rise && !carry_disable && !low |=> carry_watch_flag;
    endproperty
    a_carry_sets_flag: assert property (p_carry_sets_flag)
        else $error("carry edge did not set flag");

endmodule // power_on_reset_and_fail_detect

// File: verification/supply_partner.sv
`timescale 1ns/10ps
module supply_partner (
    // Clock
    input  wire logic        mclk,
    // Levels set by the bench, and the threshold select from the block
    input  wire logic [15:0] vdd_mv,
    input  wire logic        ce_level,
    input  wire logic        threshold_high,
    // Detector and pin
    output logic             supply_low_raw,
    output logic             ce_pin
);
    // Comparator settles once per cycle; threshold chosen by the block
    always_ff @(posedge mclk) begin
        supply_low_raw <= (vdd_mv < (threshold_high ? 16'h0DAC : 16'h0898));
    end
    always_ff @(posedge mclk) begin
        ce_pin <= ce_level;
    end
endmodule // supply_partner

// File: verification/power_on_reset_and_fail_detect_tb_top.sv
`timescale 1ns/10ps
module power_on_reset_and_fail_detect_tb_top;
    import por_pkg::*;
    localparam int CE_THR = 20;
    logic        mclk, sys_rst, ce_level, carry_set, clock_stop_cmd, flag_read;
    logic [15:0] vdd_mv;
    logic        supply_low_raw, ce_pin, threshold_high, supply_low_clear, osc_enable;
    logic        exec_enable, halt_wake_by_carry, core_init_hold, system_init;
    logic        restart_at_zero, carry_watch_flag, carry_disable;
    int          errors, cmp_count, seed;
    logic        notes[$];

    supply_partner partner (.mclk(mclk), .vdd_mv(vdd_mv), .ce_level(ce_level),
        .threshold_high(threshold_high), .supply_low_raw(supply_low_raw), .ce_pin(ce_pin));

    power_on_reset_and_fail_detect #(.CE_THR_CYCLES(CE_THR)) uut (.mclk(mclk),
        .sys_rst(sys_rst), .supply_low_raw(supply_low_raw), .threshold_high(threshold_high),
        .ce_pin(ce_pin), .carry_set(carry_set), .clock_stop_cmd(clock_stop_cmd),
        .flag_read(flag_read), .supply_low_clear(supply_low_clear), .osc_enable(osc_enable),
        .exec_enable(exec_enable), .halt_wake_by_carry(halt_wake_by_carry),
        .core_init_hold(core_init_hold), .system_init(system_init),
        .restart_at_zero(restart_at_zero), .carry_watch_flag(carry_watch_flag),
        .carry_disable(carry_disable));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    task automatic check(input string name, input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask

    // Note the flag value expected at the start pulse before raising carry
    task automatic carry_edge(input bit starts, input logic flag_exp);
        if (starts) notes.push_back(flag_exp);
        carry_set = 1'h1;
        step(1);
        carry_set = 1'h0;
        step(3);
    endtask

    task automatic pulse_read();
        flag_read = 1'h1;
        step(1);
        flag_read = 1'h0;
        step(1);
    endtask

    task automatic wrap_up();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Start pulses consume notes; a stray pulse has no note
    always @(posedge mclk) begin
        if (restart_at_zero === 1'h1) begin
            if (notes.size() == 0) begin
                check("restart", 1'h1, 1'h0);
            end else begin
                check("flag_at_start", carry_watch_flag, notes.pop_front());
                check("exec_at_start", exec_enable, 1'h1);
            end
        end
    end

    initial begin
        #100000;
        errors++;
        wrap_up();
    end

    initial begin
        seed = 32'h0A66;
        errors = 0;
        cmp_count = 0;
        sys_rst = 1'h1;
        vdd_mv = 16'h0000;
        ce_level = 1'h0;
        carry_set = 1'h0;
        clock_stop_cmd = 1'h0;
        flag_read = 1'h0;
        repeat (20) @(posedge mclk);
        #2 sys_rst = 1'h0;
        step(3);
        check("clear", supply_low_clear, 1'h1);
        check("osc", osc_enable, 1'h0);
        check("exec", exec_enable, 1'h0);
        check("hold", core_init_hold, 1'h1);
        check("disable", carry_disable, 1'h1);
        // Supply and chip enable rise together: one start only
        vdd_mv = 16'h1388;
        ce_level = 1'h1;
        step(6);
        check("clear", supply_low_clear, 1'h0);
        check("wake", halt_wake_by_carry, 1'h0);
        check("hold", core_init_hold, 1'h0);
        check("init", system_init, 1'h0);
        check("osc", osc_enable, 1'h1);
        check("exec", exec_enable, 1'h0);
        step(CE_THR);
        carry_edge(1, 1'h0);
        carry_edge(0, 1'h0);
        check("flag", carry_watch_flag, 1'h0);
        pulse_read();
        check("disable", carry_disable, 1'h0);
        carry_edge(0, 1'h0);
        check("flag", carry_watch_flag, 1'h1);
        pulse_read();
        check("flag", carry_watch_flag, 1'h0);
        // Carry edge and read in one cycle: the set wins
        carry_set = 1'h1;
        flag_read = 1'h1;
        step(1);
        carry_set = 1'h0;
        flag_read = 1'h0;
        step(3);
        check("flag_set_wins", carry_watch_flag, 1'h1);
        // Chip enable restart after the power-on start
        ce_level = 1'h0;
        step(3);
        ce_level = 1'h1;
        step(4);
        carry_edge(1, 1'h1);
        // Back-up by stop, then chip enable with supply still low
        clock_stop_cmd = 1'h1;
        step(1);
        clock_stop_cmd = 1'h0;
        step(1);
        check("osc", osc_enable, 1'h0);
        check("thr", threshold_high, 1'h0);
        vdd_mv = 16'h0BB8;
        step(6);
        check("clear", supply_low_clear, 1'h0);
        ce_level = 1'h0;
        step(2);
        ce_level = 1'h1;
        step(3);
        check("thr", threshold_high, 1'h0);
        // Restore lands CE_THR edges after the edge that loads the restore counter, before the supply trips
        step(CE_THR - 2);
        check("thr", threshold_high, 1'h0);
        step(1);
        check("thr", threshold_high, 1'h1);
        check("clear", supply_low_clear, 1'h0);
        step(6);
        check("clear", supply_low_clear, 1'h1);
        vdd_mv = 16'h1388;
        step(6);
        check("clear", supply_low_clear, 1'h0);
        carry_edge(1, 1'h0);
        // Random healthy levels, then a dip in normal operation
        repeat (8) begin
            vdd_mv = 16'h0E10 + 16'($unsigned($random(seed)) % 2000);
            step(4);
            check("clear", supply_low_clear, 1'h0);
        end
        vdd_mv = 16'h0D48;
        step(6);
        check("clear", supply_low_clear, 1'h1);
        check("osc", osc_enable, 1'h0);
        vdd_mv = 16'h1388;
        step(6);
        // Chip enable rising in the forced halt folds into one start
        ce_level = 1'h0;
        step(2);
        ce_level = 1'h1;
        step(3);
        check("exec", exec_enable, 1'h0);
        carry_edge(1, 1'h0);
        step(2);
        check("notes_left", notes.size() == 0, 1'h1);
        wrap_up();
    end
endmodule // power_on_reset_and_fail_detect_tb_top
